// ===== hw/crsd_pkg.sv
// crsd_pkg: constants and types of the control mode strap decoder
// assumes: shared by the strap sense, decode and top modules
package crsd_pkg;

    // ------------------------------------------------------------
    // strap indices and counts
    // ------------------------------------------------------------
    localparam int NUM_STRAPS    = 6;
    localparam int IDX_SWING     = 0;
    localparam int IDX_EDGE      = 1;
    localparam int IDX_CAL       = 2;
    localparam int IDX_RANGE     = 3;
    localparam int IDX_MODE      = 4;
    localparam int IDX_SECOND    = 5;
    localparam int STABLE_CYCLES = 4;
    localparam int STABLE_W      = 3;

    // ------------------------------------------------------------
    // register map and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL    = 8'h00;
    localparam logic [7:0] ADR_STATUS  = 8'h04;
    localparam logic [7:0] ADR_LEVELS  = 8'h08;
    localparam logic [7:0] ADR_CHANGES = 8'h0c;
    localparam int CTRL_HOLD_BIT       = 0;
    localparam int CTRL_RESYNC_BIT     = 1;
    localparam int STATUS_SETTLED_BIT  = 7;
    localparam int STATUS_HELD_BIT     = 8;

    // ------------------------------------------------------------
    // types and reset values
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_LOW   = 2'h0,
        LVL_HIGH  = 2'h1,
        LVL_FLOAT = 2'h2
    } crsd_level_type;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'h1,
        ST_RUN    = 3'h2,
        ST_HELD   = 3'h4
    } crsd_state_type;

    typedef struct packed {
        logic ext_mode;
        logic range_normal;
        logic swing_normal;
        logic launch_pos;
        logic ddr;
        logic cal_long;
        logic des;
    } crsd_settings_type;

    localparam crsd_settings_type RST_SETTINGS = 7'h38;
    localparam logic              RST_HOLD     = 1'b0;
    localparam logic [7:0]        RST_CHANGES  = 8'h00;

endpackage

// ===== hw/crsd_strap_if.sv
// crsd_strap_if: decoded strap levels and settings between submodules
// assumes: one sense, one decode and one core end, same clock
`timescale 1ns/10ps
interface crsd_strap_if;
    crsd_pkg::crsd_level_type [crsd_pkg::NUM_STRAPS-1:0] lvls;
    logic [2:0]                                          raw;
    crsd_pkg::crsd_settings_type                         dec;

    modport sense  (output lvls, output raw);
    modport decode (input lvls, output dec);
    modport core   (input lvls, input raw, input dec);
endinterface

// ===== hw/crsd_strap_sense.sv
// crsd_strap_sense: synchronises strap pad senses, yields three levels
// assumes: pads sensed once with weak pull-up and once with pull-down
`timescale 1ns/10ps
module crsd_strap_sense #(
    parameter int N = crsd_pkg::NUM_STRAPS
) (
    // clock, reset, enable
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // pad senses
    input  wire logic [N-1:0] up_i,
    input  wire logic [N-1:0] dn_i,
    // decoded levels
    crsd_strap_if.sense       sif
);
    typedef struct packed {
        logic [N-1:0]                        up1;
        logic [N-1:0]                        dn1;
        logic [N-1:0]                        up2;
        logic [N-1:0]                        dn2;
        crsd_pkg::crsd_level_type [N-1:0]    lvl;
    } crsd_sense_state_type;

    crsd_sense_state_type             st;
    crsd_sense_state_type             next_st;
    crsd_pkg::crsd_level_type [N-1:0] lvl_c;

    // up and down senses agree: driven; disagree: floating
    for (genvar g = 0; g < N; g++) begin : g_lvl
        assign lvl_c[g] = (st.up2[g] & st.dn2[g])   ? crsd_pkg::LVL_HIGH :
                          (!st.up2[g] & !st.dn2[g]) ? crsd_pkg::LVL_LOW  :
                                                      crsd_pkg::LVL_FLOAT;
    end

    always_comb begin
        next_st = st;
        if (rst_i) begin
            next_st = '0;
        end else if (ce_i) begin
            next_st.up1 = up_i;
            next_st.dn1 = dn_i;
            next_st.up2 = st.up1;
            next_st.dn2 = st.dn1;
            next_st.lvl = lvl_c;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign sif.lvls = st.lvl;
    assign sif.raw  = {st.up2[crsd_pkg::IDX_CAL],
                       st.up2[crsd_pkg::IDX_EDGE],
                       st.up2[crsd_pkg::IDX_SWING]};
endmodule

// ===== hw/crsd_mode_decode.sv
// crsd_mode_decode: maps strap levels onto mode and pin settings
// assumes: levels already synchronised; purely combinational
`timescale 1ns/10ps
module crsd_mode_decode (
    // levels in, settings out
    crsd_strap_if.decode sif
);
    crsd_pkg::crsd_level_type m;
    crsd_pkg::crsd_level_type s;
    crsd_pkg::crsd_level_type r;
    crsd_pkg::crsd_level_type e;
    crsd_pkg::crsd_level_type c;

    assign m = sif.lvls[crsd_pkg::IDX_MODE];
    assign s = sif.lvls[crsd_pkg::IDX_SECOND];
    assign r = sif.lvls[crsd_pkg::IDX_RANGE];
    assign e = sif.lvls[crsd_pkg::IDX_EDGE];
    assign c = sif.lvls[crsd_pkg::IDX_CAL];

    always_comb begin
        sif.dec = crsd_pkg::RST_SETTINGS;
        if (m == crsd_pkg::LVL_LOW) begin
            sif.dec.ext_mode = 1'b1;
        end else if (m == crsd_pkg::LVL_FLOAT &&
                     s != crsd_pkg::LVL_LOW) begin
            sif.dec.ext_mode = (r == crsd_pkg::LVL_FLOAT);
        end else begin
            sif.dec.ext_mode = 1'b0;
        end
        // pin functions only in pin-control mode
        if (!sif.dec.ext_mode) begin
            sif.dec.range_normal = (r != crsd_pkg::LVL_LOW);
            sif.dec.swing_normal = (sif.lvls[crsd_pkg::IDX_SWING]
                                    != crsd_pkg::LVL_LOW);
            sif.dec.ddr          = (e == crsd_pkg::LVL_FLOAT);
            sif.dec.launch_pos   = (e != crsd_pkg::LVL_LOW);
            sif.dec.cal_long     = (c == crsd_pkg::LVL_HIGH);
            sif.dec.des          = (c == crsd_pkg::LVL_FLOAT);
        end
    end
endmodule

// ===== hw/crsd_top.sv
// crsd_top: control mode strap decoder with a classic wishbone slave
// assumes: strap pads sensed as pull-up/pull-down pairs, async to clk_i
`timescale 1ns/10ps
module crsd_top #(
    parameter int AW = 8
) (
    // clock, reset, enable
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    // strap pad senses
    input  wire logic [crsd_pkg::NUM_STRAPS-1:0] strap_sense_up_i,
    input  wire logic [crsd_pkg::NUM_STRAPS-1:0] strap_sense_dn_i,
    // wishbone slave
    input  wire logic [AW-1:0]            wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic                     wb_we_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // converter core settings
    output logic                          ext_mode_o,
    output logic                          input_full_scale_range_o,
    output logic                          output_swing_level_o,
    output logic                          output_launch_edge_o,
    output logic                          output_data_clock_ddr_o,
    output logic                          calibration_delay_select_o,
    output logic                          dual_edge_sampling_o,
    output logic                          settled_o,
    // serial configuration port
    output logic                          serial_config_enable_o,
    output logic                          serial_config_clock_o,
    output logic                          serial_config_data_o,
    output logic                          serial_config_select_n_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef crsd_pkg::crsd_level_type [crsd_pkg::NUM_STRAPS-1:0]
        crsd_levels_type;

    typedef struct packed {
        logic                        ack;
        logic [31:0]                 rdat;
        logic                        hold;
        crsd_pkg::crsd_state_type    fsm;
        logic [crsd_pkg::STABLE_W-1:0] cnt;
        crsd_levels_type             last;
        crsd_pkg::crsd_settings_type set;
        logic [7:0]                  changes;
        logic                        sclk;
        logic                        sdat;
        logic                        scs_n;
    } crsd_top_state_type;

    localparam logic [crsd_pkg::STABLE_W-1:0] CNT_MAX =
        crsd_pkg::STABLE_W'(crsd_pkg::STABLE_CYCLES - 1);

    crsd_top_state_type st;
    crsd_top_state_type next_st;
    crsd_strap_if       sif ();

    logic               req;
    logic               wr_ctrl;
    logic               wr_changes;
    logic               same;
    logic               commit;
    logic               differs;
    logic [31:0]        rd_mux;
    logic [AW-1:0]      adr_w;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    crsd_strap_sense #(
        .N    (crsd_pkg::NUM_STRAPS)
    ) u_sense (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .up_i  (strap_sense_up_i),
        .dn_i  (strap_sense_dn_i),
        .sif   (sif.sense)
    );

    crsd_mode_decode u_decode (
        .sif (sif.decode)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign adr_w      = wb_adr_i;
    assign req        = wb_cyc_i & wb_stb_i & ~st.ack;
    assign wr_ctrl    = req & wb_we_i & wb_sel_i[0] &
                        (adr_w == AW'(crsd_pkg::ADR_CTRL));
    assign wr_changes = req & wb_we_i & wb_sel_i[0] &
                        (adr_w == AW'(crsd_pkg::ADR_CHANGES));

    // unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (adr_w == AW'(crsd_pkg::ADR_CTRL)) begin
            rd_mux[crsd_pkg::CTRL_HOLD_BIT] = st.hold;
        end else if (adr_w == AW'(crsd_pkg::ADR_STATUS)) begin
            rd_mux[6:0] = st.set;
            rd_mux[crsd_pkg::STATUS_SETTLED_BIT] =
                (st.fsm != crsd_pkg::ST_SETTLE);
            rd_mux[crsd_pkg::STATUS_HELD_BIT] =
                (st.fsm == crsd_pkg::ST_HELD);
        end else if (adr_w == AW'(crsd_pkg::ADR_LEVELS)) begin
            rd_mux[11:0] = st.last;
        end else if (adr_w == AW'(crsd_pkg::ADR_CHANGES)) begin
            rd_mux[7:0] = st.changes;
        end
    end

    // ------------------------------------------------------------
    // stability filter
    // ------------------------------------------------------------
    // a level must sit unchanged for several cycles before it counts,
    // so a strap caught mid-swing never flips the converter's mode
    assign same    = (sif.lvls == st.last);
    assign commit  = ce_i & ~st.hold & same & (st.cnt == CNT_MAX);
    assign differs = (sif.dec != st.set);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (rst_i) begin
            next_st.ack     = 1'b0;
            next_st.rdat    = 32'h0000_0000;
            next_st.hold    = crsd_pkg::RST_HOLD;
            next_st.fsm     = crsd_pkg::ST_SETTLE;
            next_st.cnt     = '0;
            next_st.last    = '{default: crsd_pkg::LVL_LOW};
            next_st.set     = crsd_pkg::RST_SETTINGS;
            next_st.changes = crsd_pkg::RST_CHANGES;
            next_st.sclk    = 1'b0;
            next_st.sdat    = 1'b0;
            next_st.scs_n   = 1'b1;
        end else if (ce_i) begin
            // bus answer one cycle after the request
            next_st.ack  = req;
            next_st.rdat = req ? rd_mux : st.rdat;
            if (wr_ctrl) begin
                next_st.hold = wb_dat_i[crsd_pkg::CTRL_HOLD_BIT];
            end

            // level tracking
            if (!same) begin
                next_st.last = sif.lvls;
                next_st.cnt  = '0;
            end else if (st.cnt != CNT_MAX) begin
                next_st.cnt = st.cnt + 1'b1;
            end

            // settings change only on a stable commit
            if (commit) begin
                next_st.set = sif.dec;
            end

            // change counter: an update beats a clear in the same cycle
            if (commit && differs && st.changes != 8'hff) begin
                next_st.changes = st.changes + 8'h01;
            end else if (wr_changes && !(commit && differs)) begin
                next_st.changes = 8'h00;
            end

            unique case (st.fsm)
                crsd_pkg::ST_SETTLE: begin
                    if (commit) begin
                        next_st.fsm = crsd_pkg::ST_RUN;
                    end
                end
                crsd_pkg::ST_RUN: begin
                    if (st.hold) begin
                        next_st.fsm = crsd_pkg::ST_HELD;
                    end
                end
                crsd_pkg::ST_HELD: begin
                    if (!st.hold) begin
                        next_st.fsm = crsd_pkg::ST_RUN;
                    end
                end
            endcase

            // resync restarts the settle window
            if (wr_ctrl && wb_dat_i[crsd_pkg::CTRL_RESYNC_BIT]) begin
                next_st.cnt = '0;
                next_st.fsm = crsd_pkg::ST_SETTLE;
            end

            // serial port follows the mode being entered
            if (next_st.set.ext_mode) begin
                next_st.sclk  = sif.raw[0];
                next_st.sdat  = sif.raw[1];
                next_st.scs_n = sif.raw[2];
            end else begin
                next_st.sclk  = 1'b0;
                next_st.sdat  = 1'b0;
                next_st.scs_n = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o                   = st.ack;
    assign wb_dat_o                   = st.rdat;
    assign ext_mode_o                 = st.set.ext_mode;
    assign input_full_scale_range_o   = st.set.range_normal;
    assign output_swing_level_o       = st.set.swing_normal;
    assign output_launch_edge_o       = st.set.launch_pos;
    assign output_data_clock_ddr_o    = st.set.ddr;
    assign calibration_delay_select_o = st.set.cal_long;
    assign dual_edge_sampling_o       = st.set.des;
    assign settled_o                  = (st.fsm != crsd_pkg::ST_SETTLE);
    assign serial_config_enable_o     = st.set.ext_mode;
    assign serial_config_clock_o      = st.sclk;
    assign serial_config_data_o       = st.sdat;
    assign serial_config_select_n_o   = st.scs_n;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_PIN_MODE_HIGH: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && sif.lvls[crsd_pkg::IDX_MODE] == crsd_pkg::LVL_HIGH)
        |=> !ext_mode_o && !serial_config_enable_o)
        else $error("mode strap high did not give pin control");

    AST_SERIAL_QUIET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!ext_mode_o && $past(!ext_mode_o))
        |-> (!serial_config_clock_o && !serial_config_data_o
             && serial_config_select_n_o))
        else $error("serial port moved in pin control mode");

    AST_RANGE_DECIDES: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && sif.lvls[crsd_pkg::IDX_MODE] == crsd_pkg::LVL_FLOAT
         && sif.lvls[crsd_pkg::IDX_SECOND] != crsd_pkg::LVL_LOW
         && sif.lvls[crsd_pkg::IDX_RANGE] != crsd_pkg::LVL_FLOAT)
        |=> !ext_mode_o)
        else $error("driven range strap did not give pin control");

    AST_EXT_ENTRY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && (sif.lvls[crsd_pkg::IDX_MODE] == crsd_pkg::LVL_LOW
         || (sif.lvls[crsd_pkg::IDX_MODE] == crsd_pkg::LVL_FLOAT
             && sif.lvls[crsd_pkg::IDX_SECOND] != crsd_pkg::LVL_LOW
             && sif.lvls[crsd_pkg::IDX_RANGE] == crsd_pkg::LVL_FLOAT)))
        |=> ext_mode_o && serial_config_enable_o)
        else $error("extended mode not entered");

    AST_RANGE_SEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && !sif.dec.ext_mode)
        |=> (input_full_scale_range_o ==
             ($past(sif.lvls[crsd_pkg::IDX_RANGE]) != crsd_pkg::LVL_LOW)))
        else $error("full scale range does not follow range strap");

    AST_SWING_SEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && !sif.dec.ext_mode
         && sif.lvls[crsd_pkg::IDX_SWING] == crsd_pkg::LVL_LOW)
        |=> !output_swing_level_o)
        else $error("swing strap low did not reduce swing");

    AST_EDGE_SEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && !sif.dec.ext_mode
         && sif.lvls[crsd_pkg::IDX_EDGE] != crsd_pkg::LVL_FLOAT)
        |=> !output_data_clock_ddr_o && (output_launch_edge_o ==
            ($past(sif.lvls[crsd_pkg::IDX_EDGE]) == crsd_pkg::LVL_HIGH)))
        else $error("launch edge does not follow edge strap");

    AST_DDR_SEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && !sif.dec.ext_mode
         && sif.lvls[crsd_pkg::IDX_EDGE] == crsd_pkg::LVL_FLOAT)
        |=> output_data_clock_ddr_o)
        else $error("floating edge strap did not give ddr");

    AST_CAL_SEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && !sif.dec.ext_mode
         && sif.lvls[crsd_pkg::IDX_CAL] != crsd_pkg::LVL_FLOAT)
        |=> !dual_edge_sampling_o && (calibration_delay_select_o ==
            ($past(sif.lvls[crsd_pkg::IDX_CAL]) == crsd_pkg::LVL_HIGH)))
        else $error("calibration delay does not follow strap");

    AST_DES_SEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (commit && !sif.dec.ext_mode
         && sif.lvls[crsd_pkg::IDX_CAL] == crsd_pkg::LVL_FLOAT)
        |=> dual_edge_sampling_o && !calibration_delay_select_o)
        else $error("floating calibration strap did not give des");

    AST_SERIAL_MAP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && next_st.set.ext_mode)
        |=> (serial_config_clock_o == $past(sif.raw[0]))
            && (serial_config_data_o == $past(sif.raw[1]))
            && (serial_config_select_n_o == $past(sif.raw[2])))
        else $error("serial lines not mapped from straps");

    AST_STABLE_ONLY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ($changed(st.set) && !$past(rst_i)) |-> $past(commit))
        else $error("settings changed without stable commit");

    AST_WB_ACK: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o)
        |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a one cycle answer");

endmodule

// ===== tb/crsd_strap_model.sv
// crsd_strap_model: board straps, each tied low, tied high or left open
// assumes: the design senses every pad once via pull-up, once pull-down
`timescale 1ns/10ps
module crsd_strap_model (
    // wanted levels, two bits a strap, strap0 in [1:0]
    input  wire logic [11:0] lvl_i,
    // pad senses
    output logic      [5:0]  up_o,
    output logic      [5:0]  dn_o
);
    // ------------------------------------------------------------
    // pad levels
    // ------------------------------------------------------------
    // open pad follows each pull, so the two senses disagree
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            up_o[i] = (lvl_i[2*i+:2] != 2'h0);
            dn_o[i] = (lvl_i[2*i+:2] == 2'h1);
        end
    end
endmodule

// ===== tb/tb_top.sv
// tb_top: table of strap cases, then reset, bus, hold and glitch tests
// assumes: design answers the bus one cycle after it takes a request
`timescale 1ns/10ps
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce    = 1'b1;
    logic [11:0] lvl   = 12'h555;
    logic [5:0]  up;
    logic [5:0]  dn;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic        we    = 1'b0;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    wire  [6:0]  st;
    wire  [3:0]  sp;
    logic        settled;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          compares   = 0;
    int          cycles     = 0;
    // {levels strap5..0, expected settings, expected serial lines}
    logic [22:0] rows [7] = '{{12'h555, 7'h3a, 4'h1},
        {12'h100, 7'h00, 4'h1}, {12'h569, 7'h3d, 4'h1},
        {12'h441, 7'h78, 4'hc}, {12'haaa, 7'h78, 4'hf},
        {12'h640, 7'h20, 4'h1}, {12'ha01, 7'h10, 4'h1}};

    always #2 clk_i = ~clk_i;

    crsd_strap_model straps (.lvl_i(lvl), .up_o(up), .dn_o(dn));

    crsd_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .strap_sense_up_i(up), .strap_sense_dn_i(dn),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_mode_o(st[6]), .input_full_scale_range_o(st[5]),
        .output_swing_level_o(st[4]), .output_launch_edge_o(st[3]),
        .output_data_clock_ddr_o(st[2]),
        .calibration_delay_select_o(st[1]),
        .dual_edge_sampling_o(st[0]), .settled_o(settled),
        .serial_config_enable_o(sp[3]), .serial_config_clock_o(sp[2]),
        .serial_config_data_o(sp[1]), .serial_config_select_n_o(sp[0]));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // classic cycle: held until ack is sampled high, then released
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic settle_chk(input logic [6:0] e);
        repeat (16) @(posedge clk_i);
        #1 chk({25'h0, st}, {25'h0, e});
    endtask

    // a hang still reaches the verdict
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        #1 chk({ack, settled, sp, st}, {6'h01, crsd_pkg::RST_SETTINGS});
        @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_i);
            lvl <= rows[i][22:11];
            settle_chk(rows[i][10:4]);
            chk({28'h0, sp}, {28'h0, rows[i][3:0]});
        end
        wb(8'h04, 1'b0, 32'h0, q);
        chk(q, 32'h90);
        wb(8'h10, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        // held settings ignore a steady strap change until released
        wb(8'h00, 1'b1, 32'h1, q);
        lvl <= 12'h555;
        settle_chk(7'h10);
        wb(8'h04, 1'b0, 32'h0, q);
        chk(q, 32'h190);
        wb(8'h00, 1'b1, 32'h0, q);
        settle_chk(7'h3a);
        // a two-cycle glitch must not reach the settings
        @(posedge clk_i);
        lvl <= 12'h554;
        repeat (2) @(posedge clk_i);
        lvl <= 12'h555;
        settle_chk(7'h3a);
        // frozen clock enable keeps settings through a steady change
        @(posedge clk_i);
        ce <= 1'b0;
        lvl <= 12'h100;
        settle_chk(7'h3a);
        @(posedge clk_i);
        ce <= 1'b1;
        settle_chk(7'h00);
        wb(8'h08, 1'b0, 32'h0, q);
        chk(q, 32'h100);
        wb(8'h0c, 1'b0, 32'h0, q);
        chk(q, 32'h8);
        wb(8'h0c, 1'b1, 32'h0, q);
        wb(8'h0c, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        // resync drops settled until the levels count out again
        wb(8'h00, 1'b1, 32'h2, q);
        wb(8'h04, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        repeat (8) @(posedge clk_i);
        #1 chk(settled, 1'b1);
        // reset in mid-run brings every output back to its reset value
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk({ack, settled, sp, st},
               {6'h01, crsd_pkg::RST_SETTINGS});
        @(posedge clk_i);
        rst_i <= 1'b0;
        settle_chk(7'h00);
        report_and_stop();
    end
endmodule
